// ===== hdl/rcp_cmd_map.vh
/*
 * Constants for the remote command port: opcodes, setting limits,
 * reset values and field positions.
 * Assumes inclusion by bare name before the module that uses it.
 */
`ifndef RCP_CMD_MAP_VH
`define RCP_CMD_MAP_VH

// command opcodes
`define OP_BAUD      5'h01
`define OP_SETUP     5'h02
`define OP_UNIT      5'h03
`define OP_USB_REPLY_ENDING   5'h04
`define OP_SELECT    5'h05
`define OP_DELIM     5'h06
`define OP_STATUS    5'h07
`define OP_OVERLOAD  5'h08
`define OP_LOCKOUT   5'h09
`define OP_IPPIN     5'h0A
`define OP_IPFREE    5'h0B
`define OP_MODEL     5'h0C
`define OP_CALDATE   5'h0D
`define OP_DISPLAY   5'h0E
`define OP_PAGE      5'h0F
`define OP_FACTORY   5'h10
`define OP_CHAN      5'h11
`define OP_SWEEP     5'h12

// limits
`define BAUD_MAX     8'h0D
`define SETUP_MASK   8'h1F
`define UNIT_MAX     8'h0F
`define BOOL_MAX     8'h01
`define FACT_MAX     8'h02
`define DELIM_CR     8'h0D
`define DELIM_LO     8'h20
`define DELIM_HI     8'h7D

// reset values
`define RST_BAUD     4'hB
`define RST_BAUD_X10 20'h17700
`define RST_SETUP    5'h01
`define RST_UNIT     4'h0
`define RST_USB_REPLY_ENDING  1'b0
`define RST_DELIM    8'h2C
`define RST_LOCKOUT  1'b0
`define RST_DISPLAY  1'b1
`define RST_PAGE     7'h01

// serial setup fields
`define SU_8BIT      0
`define SU_PARITY    1
`define SU_ODD       2
`define SU_ECHO      3
`define SU_PROMPT    4

// reply ending lengths
`define TERM_SHORT   2'h1
`define TERM_LONG    2'h3

`endif

// ===== hdl/rcp_cmd_port.v
/*
 * Remote command port of a measurement instrument: decodes host
 * commands, holds the communication and panel settings, and builds
 * status, overload and identification replies.
 * Assumes commands arrive already parsed into opcode, argument and
 * source, one per cycle, synchronous to clk_sys.
 */
`include "rcp_cmd_map.vh"
`default_nettype none

module rcp_cmd_port #(
  parameter [15:0] MODEL_ID = 16'h1234,  // arbitrary value
  parameter [19:0] CAL_DATE = 20'h0278C  // 010124 as decimal
) (
  input  wire        clk_sys,        // system clock
  input  wire        rst,            // sync reset
  input  wire        cmd_valid,      // command strobe
  input  wire [4:0]  cmd_code,       // opcode
  input  wire        cmd_has_arg,    // argument present
  input  wire [7:0]  cmd_arg,        // argument
  input  wire [1:0]  cmd_chan,       // channel of variant
  input  wire        cmd_from_eth,   // came over ethernet
  input  wire [31:0] cmd_src_ip,     // ethernet source ip
  input  wire [31:0] conn_req_ip,    // ip of connection request
  input  wire        dual_mode,      // dual mode active
  input  wire        ref_unlock,     // reference unlocked
  input  wire        adc_new,        // triggered adc values
  input  wire        in_ovl,         // input overload
  input  wire        data_avail,     // data available
  input  wire [7:0]  ovl_in,         // overload sources
  output wire        conn_ok,        // connection accepted
  output reg         rsp_valid,      // reply pulse
  output reg  [19:0] rsp_value,      // reply number
  output reg  [1:0]  rsp_term_len,   // ending byte count
  output reg  [23:0] rsp_term,       // ending bytes
  output reg  [3:0]  baud_code,      // baud code
  output reg  [19:0] baud_x10,       // baud rate x10
  output wire        data_8bit,      // 8 data bits
  output wire        parity_en,      // parity bit on
  output wire        parity_odd,     // odd parity
  output wire        echo_en,        // echo on
  output wire        prompt_en,      // prompt on
  output reg  [3:0]  unit_num,       // chain unit number
  output reg         addressed,      // addressed mode
  output reg  [7:0]  delim_char,     // reply delimiter
  output reg         panel_lockout,  // front panel locked
  output reg         display_on,     // display powered
  output reg  [6:0]  page_num,       // display page
  output reg         osc_amp_zero,   // osc amplitude zero pulse
  output reg         restore_pls,    // instrument default pulse
  output reg         fwd_valid,      // channel command pulse
  output reg  [4:0]  fwd_code,       // forwarded opcode
  output reg  [1:0]  fwd_chan,       // forwarded channel
  output reg  [7:0]  fwd_arg,        // forwarded argument
  output wire [7:0]  status_byte,    // status byte
  output reg  [7:0]  overload_byte   // overload byte
);

  reg  [4:0]  setup_r;
  reg         usb_term_r;
  reg         ip_lock_r;
  reg  [31:0] locked_ip_r;
  reg  [2:0]  cmd_stat_r;
  reg  [4:0]  live_stat_r;
  reg         inv_nxt;
  reg         perr_nxt;
  reg         reply_nxt;
  reg  [19:0] value_nxt;

  function [19:0] rate_x10;
    input [3:0] c;
    begin
      case (c)
        4'h0:    rate_x10 = 20'h002EE;
        4'h1:    rate_x10 = 20'h0044C;
        4'h2:    rate_x10 = 20'h00541;
        4'h3:    rate_x10 = 20'h005DC;
        4'h4:    rate_x10 = 20'h00BB8;
        4'h5:    rate_x10 = 20'h01770;
        4'h6:    rate_x10 = 20'h02EE0;
        4'h7:    rate_x10 = 20'h04650;
        4'h8:    rate_x10 = 20'h04E20;
        4'h9:    rate_x10 = 20'h05DC0;
        4'hA:    rate_x10 = 20'h0BB80;
        4'hB:    rate_x10 = 20'h17700;
        4'hC:    rate_x10 = 20'h2EE00;
        default: rate_x10 = 20'h5DC00;
      endcase
    end
  endfunction

  function page_ok;
    input [7:0] p;
    begin
      page_ok = (p >= 8'h01 && p <= 8'h0B) || (p >= 8'h15 && p <= 8'h17) ||
                (p >= 8'h28 && p <= 8'h59);
    end
  endfunction

  function delim_ok;
    input [7:0] d;
    begin
      delim_ok = (d == `DELIM_CR) || (d >= `DELIM_LO && d <= `DELIM_HI);
    end
  endfunction

  // source filter for ethernet
  wire src_ok = !cmd_from_eth || !ip_lock_r || (cmd_src_ip == locked_ip_r);
  assign conn_ok = !ip_lock_r || (conn_req_ip == locked_ip_r);

  wire is_select = (cmd_code == `OP_SELECT);
  wire take      = cmd_valid && src_ok && addressed && !is_select;
  wire sel_take  = cmd_valid && src_ok && is_select;

  assign data_8bit   = setup_r[`SU_8BIT];
  assign parity_en   = setup_r[`SU_PARITY];
  assign parity_odd  = setup_r[`SU_ODD];
  assign echo_en     = setup_r[`SU_ECHO];
  assign prompt_en   = setup_r[`SU_PROMPT];
  assign status_byte = {live_stat_r, cmd_stat_r};

  // validity and reply value
  always @* begin
    inv_nxt   = 1'b0;
    perr_nxt  = 1'b0;
    reply_nxt = !cmd_has_arg;
    value_nxt = 20'h00000;
    case (cmd_code)
      `OP_BAUD: begin
        perr_nxt  = cmd_has_arg && (cmd_arg > `BAUD_MAX);
        value_nxt = {16'h0000, baud_code};
      end
      `OP_SETUP: begin
        perr_nxt  = cmd_has_arg && ((cmd_arg & ~`SETUP_MASK) != 8'h00);
        value_nxt = {15'h0000, setup_r};
      end
      `OP_UNIT: begin
        perr_nxt  = cmd_has_arg && (cmd_arg > `UNIT_MAX);
        value_nxt = {16'h0000, unit_num};
      end
      `OP_USB_REPLY_ENDING: begin
        perr_nxt  = cmd_has_arg && (cmd_arg > `BOOL_MAX);
        value_nxt = {19'h00000, usb_term_r};
      end
      `OP_DELIM: begin
        perr_nxt  = cmd_has_arg && !delim_ok(cmd_arg);
        value_nxt = {12'h000, delim_char};
      end
      `OP_STATUS: begin
        reply_nxt = 1'b1;
        value_nxt = {12'h000, status_byte};
      end
      `OP_OVERLOAD: begin
        reply_nxt = 1'b1;
        value_nxt = {12'h000, overload_byte};
      end
      `OP_LOCKOUT: begin
        perr_nxt  = cmd_has_arg && (cmd_arg > `BOOL_MAX);
        value_nxt = {19'h00000, panel_lockout};
      end
      `OP_IPPIN, `OP_IPFREE: begin
        inv_nxt   = !cmd_from_eth;
        reply_nxt = 1'b0;
      end
      `OP_MODEL: begin
        reply_nxt = 1'b1;
        value_nxt = {4'h0, MODEL_ID};
      end
      `OP_CALDATE: begin
        reply_nxt = 1'b1;
        value_nxt = CAL_DATE;
      end
      `OP_DISPLAY: begin
        perr_nxt  = cmd_has_arg && (cmd_arg > `BOOL_MAX);
        value_nxt = {19'h00000, display_on};
      end
      `OP_PAGE: begin
        perr_nxt  = cmd_has_arg && !page_ok(cmd_arg);
        value_nxt = {13'h0000, page_num};
      end
      `OP_FACTORY: begin
        perr_nxt  = !cmd_has_arg || (cmd_arg > `FACT_MAX);
        reply_nxt = 1'b0;
      end
      `OP_CHAN: begin
        inv_nxt   = dual_mode ? (cmd_chan == 2'h0 || cmd_chan == 2'h3)
                              : (cmd_chan != 2'h0);
        reply_nxt = 1'b0;
      end
      `OP_SWEEP: begin
        inv_nxt   = dual_mode;
        reply_nxt = 1'b0;
      end
      default: begin
        inv_nxt   = 1'b1;
        reply_nxt = 1'b0;
      end
    endcase
  end

  wire exec = take && !inv_nxt && !perr_nxt;
  wire wr   = exec && cmd_has_arg;

  always @(posedge clk_sys) begin
    if (rst) begin
      baud_code     <= `RST_BAUD;
      baud_x10      <= `RST_BAUD_X10;
      setup_r       <= `RST_SETUP;
      unit_num      <= `RST_UNIT;
      usb_term_r    <= `RST_USB_REPLY_ENDING;
      ip_lock_r     <= 1'b0;
      locked_ip_r   <= 32'h00000000;
      addressed     <= 1'b1;
      delim_char    <= `RST_DELIM;
      panel_lockout <= `RST_LOCKOUT;
      display_on    <= `RST_DISPLAY;
      page_num      <= `RST_PAGE;
      cmd_stat_r    <= 3'h0;
      live_stat_r   <= 5'h00;
      overload_byte <= 8'h00;
      rsp_valid     <= 1'b0;
      rsp_value     <= 20'h00000;
      rsp_term_len  <= `TERM_SHORT;
      rsp_term      <= 24'h000000;
      osc_amp_zero  <= 1'b0;
      restore_pls   <= 1'b0;
      fwd_valid     <= 1'b0;
      fwd_code      <= 5'h00;
      fwd_chan      <= 2'h0;
      fwd_arg       <= 8'h00;
    end else begin
      live_stat_r   <= {data_avail, in_ovl, adc_new, |ovl_in, ref_unlock};
      overload_byte <= ovl_in;
      baud_x10      <= rate_x10(baud_code);
      rsp_valid     <= exec && reply_nxt;
      osc_amp_zero  <= 1'b0;
      restore_pls   <= 1'b0;
      fwd_valid     <= 1'b0;
      if (sel_take) begin
        addressed <= ({4'h0, unit_num} == cmd_arg);
      end
      if (take) begin
        cmd_stat_r <= {perr_nxt, inv_nxt, !inv_nxt && !perr_nxt};
      end
      if (exec && reply_nxt) begin
        rsp_value    <= value_nxt;
        rsp_term_len <= usb_term_r ? `TERM_LONG : `TERM_SHORT;
        rsp_term     <= usb_term_r ? {8'h00, status_byte, overload_byte}
                                   : 24'h000000;
      end
      if (wr) begin
        case (cmd_code)
          `OP_BAUD:    baud_code     <= cmd_arg[3:0];
          `OP_SETUP:   setup_r       <= cmd_arg[4:0];
          `OP_UNIT:    unit_num      <= cmd_arg[3:0];
          `OP_USB_REPLY_ENDING: usb_term_r    <= cmd_arg[0];
          `OP_DELIM:   delim_char    <= cmd_arg;
          `OP_LOCKOUT: panel_lockout <= cmd_arg[0];
          `OP_DISPLAY: display_on    <= cmd_arg[0];
          `OP_PAGE:    page_num      <= cmd_arg[6:0];
          default: begin
          end
        endcase
      end
      if (exec) begin
        case (cmd_code)
          `OP_IPPIN: begin
            ip_lock_r   <= 1'b1;
            locked_ip_r <= cmd_src_ip;
          end
          `OP_IPFREE: ip_lock_r <= 1'b0;
          `OP_CHAN, `OP_SWEEP: begin
            fwd_valid <= 1'b1;
            fwd_code  <= cmd_code;
            fwd_chan  <= cmd_chan;
            fwd_arg   <= cmd_arg;
          end
          `OP_FACTORY: begin
            restore_pls   <= 1'b1;
            osc_amp_zero  <= (cmd_arg == `FACT_MAX);
            delim_char    <= `RST_DELIM;
            panel_lockout <= `RST_LOCKOUT;
            display_on    <= `RST_DISPLAY;
            page_num      <= `RST_PAGE;
            if (cmd_arg == 8'h00) begin
              baud_code  <= `RST_BAUD;
              setup_r    <= `RST_SETUP;
              unit_num   <= `RST_UNIT;
              usb_term_r <= `RST_USB_REPLY_ENDING;
              ip_lock_r  <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule // rcp_cmd_port

`default_nettype wire

// ===== dv/rcp_host.sv
/* host model: sends one parsed command per call of send
   assumes the bench calls send just after a rising clock edge */
`default_nettype none
module rcp_host (
  input  wire logic        clk_sys,      // clock
  output var  logic        cmd_valid,    // strobe
  output var  logic [4:0]  cmd_code,     // opcode
  output var  logic        cmd_has_arg,  // set form
  output var  logic [7:0]  cmd_arg,      // argument
  output var  logic [1:0]  cmd_chan,     // channel
  output var  logic        cmd_from_eth, // over ethernet
  output var  logic [31:0] cmd_src_ip    // source ip
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd_valid = 1'b0;
  initial {cmd_code, cmd_has_arg, cmd_arg, cmd_chan, cmd_from_eth, cmd_src_ip} = '0;
  // single unit on the chain, so unit numbers stay distinct
  task automatic send(input logic [4:0] c, input logic h, input logic [7:0] a,
                      input logic [1:0] ch, input logic e, input logic [31:0] ip);
    @(posedge clk_sys);
    #1;
    {cmd_valid, cmd_code, cmd_has_arg, cmd_arg} = {1'b1, c, h, a};
    {cmd_chan, cmd_from_eth, cmd_src_ip} = {ch, e, ip};
    @(posedge clk_sys);
    #1;
    // idle arg and source ip change so stale values are never trusted
    {cmd_valid, cmd_arg, cmd_src_ip} = {1'b0, ~a, ~ip};
  endtask
endmodule // rcp_host
`default_nettype wire

// ===== dv/rcp_cmd_port_monitor.sv
/* checker for the remote command port
   assumes binding to rcp_cmd_port, one clock domain */
`default_nettype none
`include "rcp_cmd_map.vh"
module rcp_cmd_port_monitor (
  input wire logic        clk_sys,        // clock
  input wire logic        rst,            // sync reset
  input wire logic        cmd_valid,      // command strobe
  input wire logic        cmd_from_eth,   // over ethernet
  input wire logic        addressed,      // addressed mode
  input wire logic        panel_lockout,  // panel locked
  input wire logic        osc_amp_zero,   // amplitude zero pulse
  input wire logic        rsp_valid,      // reply pulse
  input wire logic [4:0]  cmd_code,       // opcode
  input wire logic [7:0]  cmd_arg,        // argument
  input wire logic [7:0]  ovl_in,         // overload sources
  input wire logic [7:0]  overload_byte,  // overload byte
  input wire logic [7:0]  delim_char,     // delimiter
  input wire logic [7:0]  status_byte,    // status byte
  input wire logic [3:0]  unit_num,       // unit number
  input wire logic [3:0]  baud_code,      // baud code
  input wire logic [19:0] baud_x10,       // baud rate x10
  input wire logic [6:0]  page_num        // display page
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ovl; !$past(rst) |-> overload_byte == $past(ovl_in); endproperty
  a_ovl: assert property (p_ovl) else $error("overload byte lag wrong");
  property p_sel;
    cmd_valid && cmd_code == `OP_SELECT && !cmd_from_eth
      |=> addressed == ($past(cmd_arg) == {4'h0, $past(unit_num)});
  endproperty
  a_sel: assert property (p_sel) else $error("select mode wrong");
  property p_keep; cmd_valid && cmd_code == `OP_SELECT |=> $stable(unit_num); endproperty
  a_keep: assert property (p_keep) else $error("unit number moved");
  property p_rsp; rsp_valid |-> $past(cmd_valid); endproperty
  a_rsp: assert property (p_rsp) else $error("reply without command");
  property p_baud; $stable(baud_code) && baud_code == 4'hD |-> baud_x10 == 20'h5DC00; endproperty
  a_baud: assert property (p_baud) else $error("top baud rate wrong");
  property p_delim; delim_char == 8'h0D || (delim_char >= 8'h20 && delim_char <= 8'h7D); endproperty
  a_delim: assert property (p_delim) else $error("delimiter out of range");
  property p_page;
    (page_num >= 7'h01 && page_num <= 7'h0B) || (page_num >= 7'h15 && page_num <= 7'h17)
      || (page_num >= 7'h28 && page_num <= 7'h59);
  endproperty
  a_page: assert property (p_page) else $error("page out of range");
  property p_lock;
    $changed(panel_lockout) |-> $past(cmd_valid)
      && ($past(cmd_code) == `OP_LOCKOUT || $past(cmd_code) == `OP_FACTORY);
  endproperty
  a_lock: assert property (p_lock) else $error("lockout changed alone");
  property p_osc;
    osc_amp_zero |-> $past(cmd_valid) && $past(cmd_code) == `OP_FACTORY && $past(cmd_arg) == 8'h02;
  endproperty
  a_osc: assert property (p_osc) else $error("amplitude zero unasked");
  property p_bad;
    cmd_valid && cmd_code == 5'h1F && addressed && !cmd_from_eth |=> status_byte[2:0] == 3'h2;
  endproperty
  a_bad: assert property (p_bad) else $error("bad opcode not flagged");
endmodule // rcp_cmd_port_monitor
bind rcp_cmd_port rcp_cmd_port_monitor rcp_cmd_port_monitor_i (.*);
`default_nettype wire

// ===== dv/tb.sv
/* self-checking bench for rcp_cmd_port with a host model
   assumes rcp_cmd_map.vh on the include path */
`default_nettype none
`include "rcp_cmd_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MID = 16'h0ABC; // arbitrary value
  localparam logic [19:0] CDT = 20'h24C60; // 150624
  logic        clk_sys = 1'b0, rst = 1'b1, dual_mode = 1'b0;
  logic        ref_unlock = 1'b0, adc_new = 1'b0, in_ovl = 1'b0, data_avail = 1'b0;
  logic [31:0] conn_req_ip = '0, ipa, ipb, cmd_src_ip;
  logic [7:0]  ovl_in = '0, a, cmd_arg, delim_char, fwd_arg, status_byte, overload_byte;
  logic        cmd_valid, cmd_has_arg, cmd_from_eth, conn_ok, rsp_valid, data_8bit;
  logic        parity_en, parity_odd, echo_en, prompt_en, addressed, panel_lockout;
  logic        display_on, osc_amp_zero, restore_pls, fwd_valid;
  logic [4:0]  cmd_code, fwd_code;
  logic [1:0]  cmd_chan, rsp_term_len, fwd_chan;
  logic [19:0] rsp_value, baud_x10;
  logic [23:0] rsp_term;
  logic [3:0]  baud_code, unit_num;
  logic [6:0]  page_num;
  logic [24:0] want;
  int fails = 0, n_tests = 0, seed = 4921, cyc = 0, k;
  int m [32];
  int dflt [8] = '{11, 1, 0, 0, 44, 0, 1, 1};
  logic [4:0]  ops [8] = '{`OP_BAUD, `OP_SETUP, `OP_UNIT, `OP_USB_REPLY_ENDING,
                           `OP_DELIM, `OP_LOCKOUT, `OP_DISPLAY, `OP_PAGE};
  logic [19:0] rate [14] = '{20'h002EE, 20'h0044C, 20'h00541, 20'h005DC, 20'h00BB8,
    20'h01770, 20'h02EE0, 20'h04650, 20'h04E20, 20'h05DC0, 20'h0BB80, 20'h17700,
    20'h2EE00, 20'h5DC00};
  rcp_host rcp_host_i (.*);
  rcp_cmd_port #(.MODEL_ID(MID), .CAL_DATE(CDT)) rcp_cmd_port_i (.*);
  initial forever #25 clk_sys = ~clk_sys;
  function automatic bit ok(input logic [4:0] op, input int v);
    case (op)
      `OP_BAUD:  return v <= 13;
      `OP_SETUP: return v < 32;
      `OP_UNIT:  return v < 16;
      `OP_DELIM: return v == 13 || (v >= 32 && v <= 125);
      `OP_PAGE:  return (v >= 1 && v <= 11) || (v >= 21 && v <= 23) || (v >= 40 && v <= 89);
      default:   return v < 2;
    endcase
  endfunction
  task automatic wrap_up;
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask
  task automatic snd(input logic [4:0] c, input logic h, input logic [7:0] v);
    rcp_host_i.send(c, h, v, 2'h0, 1'b0, 32'h0);
  endtask
  task automatic q(input logic [4:0] op);
    snd(op, 1'b0, 8'h00);
    chk(rsp_valid, 1'b1);
    chk(rsp_value, m[op]);
  endtask
  task automatic sets(input logic [4:0] op, input logic [7:0] v);
    snd(op, 1'b1, v);
    chk(status_byte[2:0], ok(op, v) ? 3'h1 : 3'h4);
    if (ok(op, v)) m[op] = v;
  endtask
  // comms settings survive unless everything is restored
  task automatic defaults(input bit all);
    for (int i = all ? 0 : 4; i < 8; i++) m[ops[i]] = dflt[i];
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    defaults(1'b1);
    repeat (5) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 8; i++) q(ops[i]);
    for (int i = 0; i < 240; i++) begin
      k = {$random(seed)} % 8;
      a = $random(seed);
      ovl_in = $random(seed);
      {ref_unlock, adc_new, in_ovl, data_avail} = $random(seed);
      sets(ops[k], a);
      q(ops[k]);
      chk({prompt_en, echo_en, parity_odd, parity_en, data_8bit}, m[`OP_SETUP]);
      chk(baud_x10, rate[m[`OP_BAUD]]);
      chk(status_byte[7:3], {data_avail, in_ovl, adc_new, |ovl_in, ref_unlock});
      chk(overload_byte, ovl_in);
      want = {m[`OP_BAUD][3:0], m[`OP_UNIT][3:0], m[`OP_DELIM][7:0], m[`OP_PAGE][6:0],
              m[`OP_DISPLAY][0], m[`OP_LOCKOUT][0]};
      chk({baud_code, unit_num, delim_char, page_num, display_on, panel_lockout}, want);
    end
    sets(`OP_BAUD, 8'h0D);
    q(`OP_BAUD);
    chk(baud_x10, rate[13]);
    snd(`OP_STATUS, 1'b0, 8'h00);
    chk(rsp_value[7:3], {data_avail, in_ovl, adc_new, |ovl_in, ref_unlock});
    snd(`OP_OVERLOAD, 1'b0, 8'h00);
    chk(rsp_value, ovl_in);
    snd(`OP_MODEL, 1'b0, 8'h00);
    chk(rsp_value, MID);
    snd(`OP_CALDATE, 1'b0, 8'h00);
    chk(rsp_value, CDT);
    for (int t = 1; t >= 0; t--) begin
      sets(`OP_USB_REPLY_ENDING, t);
      q(`OP_BAUD);
      chk({rsp_term_len, rsp_term[23:16]}, t ? 10'h300 : 10'h100);
      want = t ? {9'h000, data_avail, in_ovl, adc_new, |ovl_in, ref_unlock, 3'h1, ovl_in} : '0;
      chk(rsp_term[15:0], want[15:0]);
    end
    sets(`OP_UNIT, 8'h05);
    snd(`OP_SELECT, 1'b1, 8'h03);
    chk(addressed, 1'b0);
    snd(`OP_BAUD, 1'b0, 8'h00);
    chk(rsp_valid, 1'b0);
    snd(`OP_SELECT, 1'b1, 8'h05);
    chk({addressed, unit_num}, 5'h15);
    ipa = $random(seed);
    ipb = ~ipa;
    rcp_host_i.send(`OP_IPPIN, 1'b0, 8'h00, 2'h0, 1'b1, ipa);
    rcp_host_i.send(`OP_BAUD, 1'b0, 8'h00, 2'h0, 1'b1, ipb);
    chk(rsp_valid, 1'b0);
    conn_req_ip = ipb;
    #1;
    chk(conn_ok, 1'b0);
    @(posedge clk_sys);
    #1;
    conn_req_ip = ipa;
    #1;
    chk(conn_ok, 1'b1);
    rcp_host_i.send(`OP_IPFREE, 1'b0, 8'h00, 2'h0, 1'b1, ipa);
    rcp_host_i.send(`OP_BAUD, 1'b0, 8'h00, 2'h0, 1'b1, ipb);
    chk(rsp_valid, 1'b1);
    snd(`OP_IPPIN, 1'b0, 8'h00);
    chk(status_byte[2:0], 3'h2);
    sets(`OP_DELIM, 8'h0D);
    sets(`OP_LOCKOUT, 8'h01);
    sets(`OP_DISPLAY, 8'h00);
    snd(`OP_FACTORY, 1'b1, 8'h03);
    chk(status_byte[2:0], 3'h4);
    chk({osc_amp_zero, restore_pls, panel_lockout}, 3'h1);
    snd(`OP_FACTORY, 1'b1, 8'h02);
    chk({osc_amp_zero, restore_pls}, 2'h3);
    defaults(1'b0);
    for (int i = 0; i < 8; i++) q(ops[i]);
    snd(`OP_FACTORY, 1'b1, 8'h00);
    chk({osc_amp_zero, restore_pls}, 2'h1);
    defaults(1'b1);
    for (int i = 0; i < 8; i++) q(ops[i]);
    dual_mode = 1'b1;
    snd(`OP_SWEEP, 1'b0, 8'h00);
    chk(status_byte[2:0], 3'h2);
    rcp_host_i.send(`OP_CHAN, 1'b1, 8'h07, 2'h2, 1'b0, 32'h0);
    chk({fwd_valid, fwd_code, fwd_chan, fwd_arg}, {1'b1, `OP_CHAN, 2'h2, 8'h07});
    dual_mode = 1'b0;
    rcp_host_i.send(`OP_CHAN, 1'b1, 8'h07, 2'h1, 1'b0, 32'h0);
    chk(status_byte[2:0], 3'h2);
    snd(`OP_SWEEP, 1'b0, 8'h00);
    chk({fwd_valid, fwd_code}, {1'b1, `OP_SWEEP});
    snd(5'h1F, 1'b0, 8'h00);
    chk(status_byte[2:0], 3'h2);
    wrap_up;
  end
endmodule // tb
`default_nettype wire
